// ---- src/pump_staging_map.vh ----
// Operation
// - Supervision delay starts above top speed less margin with feedback below threshold-2%.
// - On expiry with feedback below threshold+3%, enter the selected fallback.
// - Fallback select YES: freewheel stop and show feedback-loss code.
// - Fixed-frequency fallback: run at fallback frequency, show fallback-running code.
// - Once feedback exceeds threshold+3%, fixed fallback returns to regulation and freewheel fallback returns to stop, then restarts.
// - In auxiliary mode supervision runs only with both pumps running.
// - Two modes: variable pump alone, or assisted by one auxiliary pump.
// - Reference above auxiliary start frequency launches the start delay.
// - Still above at start delay expiry: command auxiliary pump on.
// - On auxiliary start, ramp variable pump to stop frequency over start ramp.
// - Reference below auxiliary stop frequency launches the stop delay.
// - Still below at stop delay expiry: command auxiliary pump off.
// - On auxiliary stop, ramp variable pump to start frequency over stop ramp.
// - Auxiliary stopped and frequency below low speed plus offset starts sleep delay.
// - Still below at sleep delay expiry: stop variable pump, enter sleep.
// - In sleep, restart when feedback falls below the wake-up threshold.
// - Quick start ramps to quick start frequency before enabling regulation.
// - Zero-flow probing only with auxiliary stopped and frequency below enable.
// - Zero-flow probing forces low speed plus offset once per period.
// - Low speed is frequency at minimum reference, 0 up to top, default 0.
// - After low speed time limit, restart only when reference exceeds low speed.
// - A zero zero-flow period disables zero-flow probing.
`ifndef PUMP_STAGING_MAP_VH
`define PUMP_STAGING_MAP_VH
// ----------------------------------------------------------------
// Timing: one timer tick is 0.1 s; all delays and ramps count ticks.
// ----------------------------------------------------------------
`define TICK_TIME_MS      100
`define CLK_PERIOD_NS     10
`define TICK_CYCLES       ((`TICK_TIME_MS * 1000000) / `CLK_PERIOD_NS)
// Feedback is in 0.1 % units, so 2 % and 3 % become 20 and 30.
`define FB_MARGIN_LO      16'h0014
`define FB_MARGIN_HI      16'h001E
// ----------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------
`define IDX_CTRL          5'd0
`define IDX_TOP_SPD       5'd1
`define IDX_MARGIN        5'd2
`define IDX_FB_THR        5'd3
`define IDX_FB_DLY        5'd4
`define IDX_FB_FREQ       5'd5
`define IDX_AUX_ON_F      5'd6
`define IDX_AUX_ON_D      5'd7
`define IDX_AUX_ON_R      5'd8
`define IDX_AUX_OFF_F     5'd9
`define IDX_AUX_OFF_D     5'd10
`define IDX_AUX_OFF_R     5'd11
`define IDX_LOW_SPD       5'd12
`define IDX_SLEEP_OFS     5'd13
`define IDX_SLEEP_DLY     5'd14
`define IDX_WAKE_THR      5'd15
`define IDX_QS_FREQ       5'd16
`define IDX_ACCEL         5'd17
`define IDX_ZF_EN_F       5'd18
`define IDX_ZF_OFS        5'd19
`define IDX_ZF_PERIOD     5'd20
`define IDX_LS_LIMIT      5'd21
`define IDX_STATUS        5'd22
`define IDX_LAST_CFG      5'd21
// Control register fields.
`define CTRL_MODE_BIT     0
`define CTRL_FB_SEL_LO    1
`define CTRL_FB_SEL_HI    2
`define CTRL_QS_BIT       3
`define FB_SEL_OFF        2'd0
`define FB_SEL_YES        2'd1
`define FB_SEL_FIXED      2'd2
// Fault codes shown on the status port.
`define CODE_NONE         2'd0
`define CODE_FB_LOSS      2'd1
`define CODE_FB_RUNNING   2'd2
// Reset values (frequencies 0.1 Hz, times 0.1 s, levels 0.1 %).
`define RST_CTRL          16'h0000
`define RST_TOP_SPD       16'h01F4
`define RST_DEFAULT       16'h0000
`endif

// ---- src/delay_timer.v ----
`timescale 1ns/1ps
module delay_timer (
  // Clock and reset.
  input  wire        sys_clk_in,
  input  wire        reset_in,
  // Condition, time base and delay.
  input  wire        arm_in,
  input  wire        tick_in,
  input  wire [15:0] limit_in,
  // Expiry level, only while the condition still holds.
  output wire        expired_out
);
  reg [15:0] count_r;

  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_r <= 16'h0000;
    end else if (!arm_in) begin
      count_r <= 16'h0000;
    end else if (tick_in && (count_r < limit_in)) begin
      count_r <= count_r + 16'h0001;
    end
  end

  assign expired_out = arm_in && (count_r >= limit_in);
endmodule // delay_timer

// ---- src/ramp_gen.v ----
`timescale 1ns/1ps
module ramp_gen (
  // Clock and reset.
  input  wire        sys_clk_in,
  input  wire        reset_in,
  // Ramp request.
  input  wire        load_in,
  input  wire        tick_in,
  input  wire [15:0] from_in,
  input  wire [15:0] to_in,
  input  wire [15:0] time_in,
  // Ramp output.
  output reg  [15:0] value_out,
  output reg         busy_out
);
  reg  [15:0] target_r;
  reg  [15:0] step_r;
  reg  [15:0] left_r;
  reg         up_r;
  wire [15:0] span;

  assign span = (to_in >= from_in) ? (to_in - from_in) : (from_in - to_in);

  // The last tick lands exactly on the target, so truncation of the step never leaves an error.
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      value_out <= 16'h0000;
      busy_out  <= 1'b0;
      target_r  <= 16'h0000;
      step_r    <= 16'h0000;
      left_r    <= 16'h0000;
      up_r      <= 1'b0;
    end else if (load_in) begin
      target_r <= to_in;
      up_r     <= (to_in >= from_in);
      if (time_in == 16'h0000) begin
        value_out <= to_in;
        busy_out  <= 1'b0;
      end else begin
        value_out <= from_in;
        busy_out  <= 1'b1;
        step_r    <= span / time_in;
        left_r    <= time_in;
      end
    end else if (busy_out && tick_in) begin
      if (left_r == 16'h0001) begin
        value_out <= target_r;
        busy_out  <= 1'b0;
      end else begin
        value_out <= up_r ? (value_out + step_r) : (value_out - step_r);
        left_r    <= left_r - 16'h0001;
      end
    end
  end
endmodule // ramp_gen

// ---- src/pump_staging_controller.v ----
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pump_staging_map.vh"
module pump_staging_controller #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset.
  input  wire        sys_clk_in,
  input  wire        reset_in,
  // Wishbone classic slave.
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  // Process inputs.
  input  wire        run_cmd_in,
  input  wire [15:0] pi_freq_ref_in,
  input  wire [15:0] feedback_in,
  // Drive outputs.
  output reg  [15:0] motor_freq_out,
  output reg         motor_run_out,
  output reg         freewheel_out,
  output reg         pi_enable_out,
  output reg         aux_pump_cmd_out,
  output reg  [1:0]  fault_code_out,
  output reg  [2:0]  state_out
);
  // ----------------------------------------------------------------
  // States.
  // ----------------------------------------------------------------
  localparam ST_STOP    = 3'd0;
  localparam ST_QSTART  = 3'd1;
  localparam ST_REG     = 3'd2;
  localparam ST_STAGE   = 3'd3;
  localparam ST_SLEEP   = 3'd4;
  localparam ST_FB_STOP = 3'd5;
  localparam ST_FB_FIX  = 3'd6;
  localparam ST_LS_HOLD = 3'd7;

  // ----------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------
  reg  [15:0] cfg_r [0:21];
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [31:0] tick_cnt_r;
  reg         tick_r;
  reg  [15:0] zf_cnt_r;
  reg         zf_probe_r;
  reg         aux_cmd_nxt;
  reg         ramp_load;
  reg  [15:0] ramp_to;
  reg  [15:0] ramp_time;
  reg  [15:0] freq_nxt;
  reg  [1:0]  code_nxt;
  wire        bus_req;
  wire [4:0]  idx;
  wire [15:0] ramp_value;
  wire        ramp_busy;
  integer     i;

  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign idx     = wb_adr_in[6:2];

  // Out-of-range indices and the upper address bit answer with zero and drop writes.
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (i = 0; i <= 21; i = i + 1) begin
        cfg_r[i] <= `RST_DEFAULT;
      end
      cfg_r[`IDX_CTRL]    <= `RST_CTRL;
      cfg_r[`IDX_TOP_SPD] <= `RST_TOP_SPD;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_req && wb_we_in && !wb_adr_in[7] && (idx <= `IDX_LAST_CFG)) begin
        if (wb_sel_in[0]) begin
          cfg_r[idx][7:0] <= wb_dat_in[7:0];
        end
        if (wb_sel_in[1]) begin
          cfg_r[idx][15:8] <= wb_dat_in[15:8];
        end
      end
      if (bus_req && !wb_we_in) begin
        if (wb_adr_in[7]) begin
          wb_dat_out <= 32'h0000_0000;
        end else if (idx <= `IDX_LAST_CFG) begin
          wb_dat_out <= {16'h0000, cfg_r[idx]};
        end else if (idx == `IDX_STATUS) begin
          wb_dat_out <= {24'h00_0000, aux_pump_cmd_out, motor_run_out, fault_code_out,
                         1'b0, state_r};
        end else begin
          wb_dat_out <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Settings in use.
  // ----------------------------------------------------------------
  wire        aux_mode  = cfg_r[`IDX_CTRL][`CTRL_MODE_BIT];
  wire [1:0]  fb_sel    = cfg_r[`IDX_CTRL][`CTRL_FB_SEL_HI:`CTRL_FB_SEL_LO];
  wire        qs_en     = cfg_r[`IDX_CTRL][`CTRL_QS_BIT];
  wire [15:0] top_spd   = cfg_r[`IDX_TOP_SPD];
  wire [15:0] low_spd   = (cfg_r[`IDX_LOW_SPD] > top_spd) ? top_spd
                          : cfg_r[`IDX_LOW_SPD];
  wire [15:0] fb_thr    = cfg_r[`IDX_FB_THR];
  wire [15:0] on_freq   = cfg_r[`IDX_AUX_ON_F];
  wire [15:0] off_freq  = cfg_r[`IDX_AUX_OFF_F];
  wire [15:0] sleep_thr = low_spd + cfg_r[`IDX_SLEEP_OFS];
  wire [15:0] top_thr   = (top_spd > cfg_r[`IDX_MARGIN]) ?
                          (top_spd - cfg_r[`IDX_MARGIN]) : 16'h0000;
  wire [15:0] fb_lo     = (fb_thr > `FB_MARGIN_LO) ? (fb_thr - `FB_MARGIN_LO) : 16'h0000;
  wire [15:0] fb_hi     = fb_thr + `FB_MARGIN_HI;
  wire [15:0] ref_clamp = (pi_freq_ref_in < low_spd) ? low_spd :
                          ((pi_freq_ref_in > top_spd) ? top_spd : pi_freq_ref_in);

  // ----------------------------------------------------------------
  // Time base of 0.1 s.
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Delay timers, each cancelled as soon as its condition lapses.
  // ----------------------------------------------------------------
  wire regulating = (state_r == ST_REG);
  wire sup_arm = regulating && (fb_sel != `FB_SEL_OFF) && (motor_freq_out > top_thr)
                 && (feedback_in < fb_lo) && (!aux_mode || aux_pump_cmd_out);
  wire on_arm  = regulating && aux_mode && !aux_pump_cmd_out
                 && (pi_freq_ref_in > on_freq);
  wire off_arm = regulating && aux_mode && aux_pump_cmd_out
                 && (pi_freq_ref_in < off_freq);
  wire slp_arm = regulating && !aux_pump_cmd_out && (motor_freq_out < sleep_thr);
  wire ls_arm  = regulating && (cfg_r[`IDX_LS_LIMIT] != 16'h0000)
                 && (pi_freq_ref_in <= low_spd);
  wire sup_exp;
  wire on_exp;
  wire off_exp;
  wire slp_exp;
  wire ls_exp;

  delay_timer u_sup_timer (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .arm_in      (sup_arm),
    .tick_in     (tick_r),
    .limit_in    (cfg_r[`IDX_FB_DLY]),
    .expired_out (sup_exp)
  );
  delay_timer u_on_timer (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .arm_in      (on_arm),
    .tick_in     (tick_r),
    .limit_in    (cfg_r[`IDX_AUX_ON_D]),
    .expired_out (on_exp)
  );
  delay_timer u_off_timer (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .arm_in      (off_arm),
    .tick_in     (tick_r),
    .limit_in    (cfg_r[`IDX_AUX_OFF_D]),
    .expired_out (off_exp)
  );
  delay_timer u_sleep_timer (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .arm_in      (slp_arm),
    .tick_in     (tick_r),
    .limit_in    (cfg_r[`IDX_SLEEP_DLY]),
    .expired_out (slp_exp)
  );
  delay_timer u_ls_timer (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .arm_in      (ls_arm),
    .tick_in     (tick_r),
    .limit_in    (cfg_r[`IDX_LS_LIMIT]),
    .expired_out (ls_exp)
  );

  ramp_gen u_ramp (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .load_in    (ramp_load),
    .tick_in    (tick_r),
    .from_in    (motor_freq_out),
    .to_in      (ramp_to),
    .time_in    (ramp_time),
    .value_out  (ramp_value),
    .busy_out   (ramp_busy)
  );

  // ----------------------------------------------------------------
  // Zero-flow probe: one tick at low speed plus offset per period.
  // ----------------------------------------------------------------
  wire zf_active = regulating && !aux_pump_cmd_out && (cfg_r[`IDX_ZF_PERIOD] != 16'h0000)
                   && (motor_freq_out < cfg_r[`IDX_ZF_EN_F]);

  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      zf_cnt_r   <= 16'h0000;
      zf_probe_r <= 1'b0;
    end else if (!zf_active) begin
      zf_cnt_r   <= 16'h0000;
      zf_probe_r <= 1'b0;
    end else if (tick_r) begin
      if (zf_cnt_r >= cfg_r[`IDX_ZF_PERIOD] - 16'h0001) begin
        zf_cnt_r   <= 16'h0000;
        zf_probe_r <= 1'b1;
      end else begin
        zf_cnt_r   <= zf_cnt_r + 16'h0001;
        zf_probe_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Staging and supervision state machine.
  // ----------------------------------------------------------------
  always @* begin
    state_nxt   = state_r;
    aux_cmd_nxt = aux_pump_cmd_out;
    ramp_load   = 1'b0;
    ramp_to     = 16'h0000;
    ramp_time   = 16'h0000;
    freq_nxt    = motor_freq_out;
    code_nxt    = `CODE_NONE;
    case (state_r)
      ST_STOP: begin
        freq_nxt = 16'h0000;
        if (run_cmd_in) begin
          if (qs_en) begin
            state_nxt = ST_QSTART;
            ramp_load = 1'b1;
            ramp_to   = cfg_r[`IDX_QS_FREQ];
            ramp_time = cfg_r[`IDX_ACCEL];
          end else begin
            state_nxt = ST_REG;
          end
        end
      end
      ST_QSTART: begin
        freq_nxt = ramp_value;
        if (!ramp_busy && !ramp_load) begin
          state_nxt = ST_REG;
        end
      end
      ST_REG: begin
        freq_nxt = zf_probe_r ? (low_spd + cfg_r[`IDX_ZF_OFS]) : ref_clamp;
        if (sup_exp && (feedback_in < fb_hi)) begin
          freq_nxt  = (fb_sel == `FB_SEL_YES) ? 16'h0000 : cfg_r[`IDX_FB_FREQ];
          state_nxt = (fb_sel == `FB_SEL_YES) ? ST_FB_STOP : ST_FB_FIX;
        end else if (on_exp) begin
          aux_cmd_nxt = 1'b1;
          state_nxt   = ST_STAGE;
          ramp_load   = 1'b1;
          ramp_to     = off_freq;
          ramp_time   = cfg_r[`IDX_AUX_ON_R];
        end else if (off_exp) begin
          aux_cmd_nxt = 1'b0;
          state_nxt   = ST_STAGE;
          ramp_load   = 1'b1;
          ramp_to     = on_freq;
          ramp_time   = cfg_r[`IDX_AUX_OFF_R];
        end else if (slp_exp) begin
          state_nxt = ST_SLEEP;
        end else if (ls_exp) begin
          state_nxt = ST_LS_HOLD;
        end
      end
      ST_STAGE: begin
        freq_nxt = ramp_value;
        if (!ramp_busy) begin
          state_nxt = ST_REG;
        end
      end
      ST_SLEEP: begin
        freq_nxt = 16'h0000;
        if (feedback_in < cfg_r[`IDX_WAKE_THR]) begin
          state_nxt = ST_STOP;
        end
      end
      ST_FB_STOP: begin
        freq_nxt = 16'h0000;
        if (feedback_in > fb_hi) begin
          state_nxt = ST_STOP;
        end
      end
      ST_FB_FIX: begin
        freq_nxt = cfg_r[`IDX_FB_FREQ];
        if (feedback_in > fb_hi) begin
          state_nxt = ST_REG;
        end
      end
      ST_LS_HOLD: begin
        freq_nxt = 16'h0000;
        if (pi_freq_ref_in > low_spd) begin
          state_nxt = ST_STOP;
        end
      end
      default: begin
        state_nxt = ST_STOP;
      end
    endcase
    if (!run_cmd_in) begin
      state_nxt   = ST_STOP;
      aux_cmd_nxt = 1'b0;
      freq_nxt    = 16'h0000;
      code_nxt    = `CODE_NONE;
    end
    if (!aux_mode) begin
      aux_cmd_nxt = 1'b0;
    end
    // The code follows the state being entered, so it never lags the state by a cycle.
    if (state_nxt == ST_FB_STOP) begin
      code_nxt = `CODE_FB_LOSS;
    end else if (state_nxt == ST_FB_FIX) begin
      code_nxt = `CODE_FB_RUNNING;
    end
  end

  // Entering the stop or sleep state also drops the auxiliary pump.
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r          <= ST_STOP;
      state_out        <= ST_STOP;
      motor_freq_out   <= 16'h0000;
      motor_run_out    <= 1'b0;
      freewheel_out    <= 1'b0;
      pi_enable_out    <= 1'b0;
      aux_pump_cmd_out <= 1'b0;
      fault_code_out   <= `CODE_NONE;
    end else begin
      state_r          <= state_nxt;
      state_out        <= state_nxt;
      motor_freq_out   <= freq_nxt;
      motor_run_out    <= (state_nxt == ST_QSTART) || (state_nxt == ST_REG) ||
                          (state_nxt == ST_STAGE) || (state_nxt == ST_FB_FIX);
      freewheel_out    <= (state_nxt == ST_FB_STOP);
      pi_enable_out    <= (state_nxt == ST_REG) || (state_nxt == ST_STAGE);
      aux_pump_cmd_out <= ((state_nxt == ST_SLEEP) || (state_nxt == ST_STOP)) ? 1'b0
                          : aux_cmd_nxt;
      fault_code_out   <= code_nxt;
    end
  end
endmodule // pump_staging_controller

// ---- test/pressure_sensor_model.sv ----
`timescale 1ns/1ps
module pressure_sensor_model (
  // Clock and reset.
  input  wire        sys_clk_in,
  input  wire        reset_in,
  // Contactor and demand.
  input  wire        aux_cmd_in,
  input  wire [15:0] demand_in,
  // Sensor reading.
  output reg  [15:0] feedback_out
);
  // A closed contactor lifts pressure by a fixed step; one cycle of lag stands for the sensor.
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      feedback_out <= 16'h0000;
    end else begin
      feedback_out <= demand_in + (aux_cmd_in ? 16'h0032 : 16'h0000);
    end
  end
endmodule // pressure_sensor_model

// ---- test/pump_staging_controller_asserts.sv ----
`timescale 1ns/1ps
module pump_staging_checker #(
  parameter TICK_CYCLES = 10
) (
  input wire       sys_clk_in,
  input wire       reset_in,
  input wire       run_cmd_in,
  input wire       motor_run_out,
  input wire       freewheel_out,
  input wire       pi_enable_out,
  input wire       aux_pump_cmd_out,
  input wire [1:0] fault_code_out,
  input wire [2:0] state_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  property p_fb_stop;
    state_out == 3'd5 |-> fault_code_out == 2'd1 && freewheel_out && !motor_run_out;
  endproperty
  a_fb_stop: assert property (p_fb_stop) else $error("freewheel fallback outputs wrong");
  property p_fb_fix;
    state_out == 3'd6 |-> fault_code_out == 2'd2 && motor_run_out && !freewheel_out;
  endproperty
  a_fb_fix: assert property (p_fb_fix) else $error("fixed fallback outputs wrong");
  property p_fix_back;
    $past(state_out) == 3'd6 && state_out != 3'd6 && $past(run_cmd_in) |-> state_out == 3'd2;
  endproperty
  a_fix_back: assert property (p_fix_back) else $error("fixed fallback left wrongly");
  property p_start_ramp;
    $rose(aux_pump_cmd_out) |-> state_out == 3'd3;
  endproperty
  a_start_ramp: assert property (p_start_ramp) else $error("no ramp at aux start");
  property p_stop_ramp;
    $fell(aux_pump_cmd_out) && run_cmd_in && $past(run_cmd_in) |-> state_out == 3'd3;
  endproperty
  a_stop_ramp: assert property (p_stop_ramp) else $error("no ramp at aux stop");
  property p_sleep_aux;
    $rose(state_out == 3'd4) |-> !$past(aux_pump_cmd_out);
  endproperty
  a_sleep_aux: assert property (p_sleep_aux) else $error("sleep with aux running");
  property p_sleep;
    state_out == 3'd4 |-> !motor_run_out && !aux_pump_cmd_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("pump runs in sleep");
  property p_wake;
    $past(state_out) == 3'd4 && state_out != 3'd4 && run_cmd_in |->
      state_out == 3'd0 ##1 (state_out == 3'd1 || state_out == 3'd2);
  endproperty
  a_wake: assert property (p_wake) else $error("wake path wrong");
  property p_quick;
    state_out == 3'd1 |-> !pi_enable_out;
  endproperty
  a_quick: assert property (p_quick) else $error("regulator on during quick start");
endmodule // pump_staging_checker
bind pump_staging_controller pump_staging_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .run_cmd_in(run_cmd_in),
  .motor_run_out(motor_run_out), .freewheel_out(freewheel_out),
  .pi_enable_out(pi_enable_out), .aux_pump_cmd_out(aux_pump_cmd_out),
  .fault_code_out(fault_code_out), .state_out(state_out));

// ---- test/pump_staging_controller_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module pump_staging_controller_bench;
  logic        sys_clk, rst, cyc, stb, we, ack, run, aux, mrun, fw, pien, chk_r;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dout, e_v;
  logic [15:0] pi_ref, fb, demand, mfreq;
  logic [1:0]  code;
  logic [2:0]  st;
  logic [31:0] exp_q[$];
  int          bad_count, compares, i;
  // Address and value of each setting; the zero-flow offset stays below the sleep offset.
  logic [7:0]  cfg_a [0:13] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
                                8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h4C, 8'h00};
  logic [15:0] cfg_v [0:13] = '{16'h0190, 16'h0002, 16'h0003, 16'h012C, 16'h0002,
                                16'h0003, 16'h0064, 16'h0032, 16'h0002, 16'h012C,
                                16'h00C8, 16'h0002, 16'h0014, 16'h0009};
  pump_staging_controller #(.TICK_CYCLES(10)) dut_u (
    .sys_clk_in(sys_clk), .reset_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(dout), .wb_ack_out(ack), .run_cmd_in(run), .pi_freq_ref_in(pi_ref),
    .feedback_in(fb), .motor_freq_out(mfreq), .motor_run_out(mrun),
    .freewheel_out(fw), .pi_enable_out(pien), .aux_pump_cmd_out(aux),
    .fault_code_out(code), .state_out(st));
  pressure_sensor_model model_u (.sys_clk_in(sys_clk), .reset_in(rst),
    .aux_cmd_in(aux), .demand_in(demand), .feedback_out(fb));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  // -------------------------------------------------------------
  // Read data is judged by its own process when ack appears.
  // -------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (ack === 1'b1 && chk_r) begin
      e_v = exp_q.pop_front();
      `CHK("wb_dat", e_v, dout)
    end
  end
  task tally_and_finish;
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [15:0] d,
           input logic c, input logic [15:0] e);
    @(posedge sys_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {16'h0000, d}; chk_r <= c;
    if (c) exp_q.push_back({16'h0000, e});
    do @(posedge sys_clk); while (ack !== 1'b1);
    rdat = dout;
    cyc <= 0; stb <= 0;
  endtask
  // Polling hides the transient states; only the settled status is judged.
  task poll(input logic [7:0] e);
    for (int k = 0; k < 400; k++) begin
      bus(8'h58, 0, 16'h0000, 0, 16'h0000);
      if (rdat[7:0] === e) break;
    end
    bus(8'h58, 0, 16'h0000, 1, {8'h00, e});
  endtask
  task setp(input logic r, input logic [15:0] p, input logic [15:0] d);
    @(posedge sys_clk);
    run <= r; pi_ref <= p; demand <= d;
  endtask
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF; wdat = 0; chk_r = 0;
    run = 0; pi_ref = 0; demand = 0; bad_count = 0; compares = 0;
    void'($urandom(32'h0000_84C1));
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    bus(8'h04, 0, 16'h0000, 1, 16'h01F4);
    bus(8'h30, 0, 16'h0000, 1, 16'h0000);
    bus(8'h30, 1, 16'h0700, 0, 16'h0000);
    bus(8'h30, 0, 16'h0000, 1, 16'h0700);
    bus(8'h80, 1, 16'hBEEF, 0, 16'h0000);
    bus(8'h80, 0, 16'h0000, 1, 16'h0000);
    bus(8'h58, 1, 16'h00FF, 0, 16'h0000);
    bus(8'h58, 0, 16'h0000, 1, 16'h0000);
    for (i = 0; i < 14; i++) bus(cfg_a[i], 1, cfg_v[i], 0, 16'h0000);
    setp(1, 16'h015E, 16'h01F4);
    poll(8'h42);
    setp(1, 16'h01C2, 16'h01F4);
    repeat (10) @(posedge sys_clk);
    setp(1, 16'h015E, 16'h01F4);
    repeat (40) @(posedge sys_clk);
    bus(8'h58, 0, 16'h0000, 1, 16'h0042);
    setp(1, 16'h019A + 16'($urandom_range(0, 80)), 16'h01F4);
    poll(8'hC2);
    setp(1, 16'h00FA, 16'h01F4);
    poll(8'h42);
    setp(1, 16'h0078, 16'h01F4);
    poll(8'h04);
    setp(1, 16'h015E, 16'h00C8);
    poll(8'h42);
    bus(8'h08, 1, 16'h0014, 0, 16'h0000);
    bus(8'h0C, 1, 16'h01F4, 0, 16'h0000);
    bus(8'h10, 1, 16'h0002, 0, 16'h0000);
    bus(8'h14, 1, 16'h00C8, 0, 16'h0000);
    bus(8'h00, 1, 16'h0004, 0, 16'h0000);
    setp(1, 16'h01F4, 16'h0064);
    poll(8'h66);
    `CHK("motor_freq", 16'h00C8, mfreq)
    setp(1, 16'h01F4, 16'h0258);
    poll(8'h42);
    bus(8'h00, 1, 16'h0002, 0, 16'h0000);
    setp(1, 16'h01F4, 16'h0064);
    poll(8'h15);
    setp(1, 16'h01F4, 16'h0258);
    poll(8'h42);
    bus(8'h48, 1, 16'h0190, 0, 16'h0000);
    bus(8'h50, 1, 16'h0003, 0, 16'h0000);
    setp(1, 16'h012C, 16'h0258);
    for (i = 0; i < 200 && mfreq !== 16'h0078; i++) @(posedge sys_clk);
    `CHK("zf_probe", 16'h0078, mfreq)
    bus(8'h54, 1, 16'h0001, 0, 16'h0000);
    setp(1, 16'h0050, 16'h0258);
    poll(8'h07);
    setp(1, 16'h015E, 16'h0258);
    poll(8'h42);
    tally_and_finish();
  end
endmodule // pump_staging_controller_bench
